// *** rtl/ldcfg_regs.sv ***
// Config register bank for the first serial port and the wake control unit
// What this block does
// RULE1: Serial config register resets to 02h, normal power, other bits clear.
// RULE2: Bit 7 set allows serial bank switching; clear disables it, default.
// RULE3: Bit 2 is read-only busy: 1 while a serial transfer runs.
// RULE4: Bit 1 clear on active port stops its clock, outputs inactive.
// RULE5: In low power the ring indicate input may still raise an interrupt.
// RULE6: Low power keeps serial registers accessible; only deactivation blocks them.
// RULE7: Bit 1 set, the default, enables the clock; port works when active.
// RULE8: Bit 0 set and port inactive floats all its output pins.
// RULE9: Wake activate resets 00h; bit 0 clear blocks runtime register access.
// RULE10: Deactivated wake unit keeps its registers and wake detection running.
// RULE11: Base low bits 4-0 read 0, 32-byte aligned; both bases reset 00h.
// RULE12: Wake interrupt type resets 03h; only bit 1 writable.
// RULE13: Wake DMA report registers read-only, always 04h.
// RULE14: Base high and interrupt number are fully read-write.
// RULE15: Writes to read-only or reserved bits do nothing; bits 6-3 read 0.
// RULE16: With bank switching disabled, extended bank accesses are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "ldcfg_defines.svh"

module ldcfg_regs (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clk_en,
	// Avalon-MM slave, word addressed by register index
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// First serial port side
	input wire logic serial_busy,
	input wire logic serial_ring_indicate_input,
	input wire logic serial_ring_irq_enable,
	input wire logic serial_ext_bank_req,
	output logic serial_ext_bank_grant,
	output logic serial_active,
	output logic serial_clk_enable,
	output logic serial_outputs_inactive,
	output logic serial_outputs_hiz,
	output logic serial_ring_irq,
	output logic serial_regs_accessible,
	// Wake control unit side
	output logic wake_runtime_access_en,
	output logic wake_detect_enable,
	output ldcfg_pkg::ldcfg_byte_t wake_base_high,
	output ldcfg_pkg::ldcfg_byte_t wake_base_low,
	output ldcfg_pkg::ldcfg_byte_t wake_irq_number,
	output ldcfg_pkg::ldcfg_byte_t wake_irq_type
);
	import ldcfg_pkg::*;

	ldcfg_state_t state_reg;
	ldcfg_byte_t serial_config_reg;
	ldcfg_byte_t serial_activate_reg;
	ldcfg_byte_t wake_activate_reg;
	ldcfg_byte_t wake_base_high_reg;
	ldcfg_byte_t wake_base_low_reg;
	ldcfg_byte_t wake_irq_number_reg;
	ldcfg_byte_t wake_irq_type_reg;
	ldcfg_byte_t read_next;
	logic [31:0] readdata_reg;
	logic wr_take;
	ldcfg_byte_t wbyte;
	// One write strobe per writable register
	logic wr_serial_config;
	logic wr_serial_activate;
	logic wr_wake_activate;
	logic wr_wake_base_high;
	logic wr_wake_base_low;
	logic wr_wake_irq_number;
	logic wr_wake_irq_type;

	// -----------------------------------------------------------------
	// Bus handshake
	// -----------------------------------------------------------------
	// Each access waits one cycle, answered in the DONE state
	assign avs_waitrequest = !(state_reg == LDCFG_DONE);
	assign wr_take = clk_en && avs_write && state_reg == LDCFG_DONE;
	assign wbyte = avs_writedata[7:0];

	// -----------------------------------------------------------------
	// Write decode
	// -----------------------------------------------------------------
	// Strobes fire only in the answer cycle, so clk_en low freezes them
	assign wr_serial_config = wr_take &&
		avs_address == `LDCFG_IDX_SERIAL_CONFIG;
	assign wr_serial_activate = wr_take &&
		avs_address == `LDCFG_IDX_SERIAL_ACTIVATE;
	assign wr_wake_activate = wr_take &&
		avs_address == `LDCFG_IDX_WAKE_ACTIVATE;
	assign wr_wake_base_high = wr_take &&
		avs_address == `LDCFG_IDX_WAKE_BASE_HIGH;
	assign wr_wake_base_low = wr_take &&
		avs_address == `LDCFG_IDX_WAKE_BASE_LOW;
	assign wr_wake_irq_number = wr_take &&
		avs_address == `LDCFG_IDX_WAKE_IRQ_NUMBER;
	// DMA report indices get no strobe: they never take writes
	assign wr_wake_irq_type = wr_take &&
		avs_address == `LDCFG_IDX_WAKE_IRQ_TYPE; // RULE13

	// Request sequencer
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_reg <= LDCFG_IDLE;
		end else if (clk_en) begin
			unique case (state_reg)
				LDCFG_IDLE: begin
					if (avs_read || avs_write) begin
						state_reg <= LDCFG_DONE;
					end
				end
				LDCFG_DONE: begin
					state_reg <= LDCFG_IDLE;
				end
				default: begin
					state_reg <= LDCFG_IDLE;
				end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Serial port registers
	// -----------------------------------------------------------------
	// Config register: only bits 7, 1, 0 take writes
	// Busy bit is never stored; the read mux shows it live
	ldcfg_mask_reg #(
		.RESET_VALUE(`LDCFG_RST_SERIAL_CONFIG), // RULE1
		.WRITE_MASK(`LDCFG_SP_WRITE_MASK) // RULE15
	) i_serial_config (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.write_strobe(wr_serial_config),
		.write_data(wbyte),
		.value(serial_config_reg)
	);

	// Serial activate register, bit 0 only
	ldcfg_mask_reg #(
		.RESET_VALUE(`LDCFG_RST_SERIAL_ACTIVATE),
		.WRITE_MASK(`LDCFG_ACTIVATE_WRITE_MASK)
	) i_serial_activate (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.write_strobe(wr_serial_activate),
		.write_data(wbyte),
		.value(serial_activate_reg)
	);

	// Serial port controls derived from config and activation
	assign serial_active = serial_activate_reg[0];
	// Bank switching only passes while enabled
	assign serial_ext_bank_grant = serial_ext_bank_req &&
		serial_config_reg[`LDCFG_SP_BANK_EN_BIT]; // RULE2 RULE16
	// Clock runs only when active and in normal power
	assign serial_clk_enable = serial_active &&
		serial_config_reg[`LDCFG_SP_POWER_BIT]; // RULE4 RULE7
	assign serial_outputs_inactive = !serial_clk_enable; // RULE4
	assign serial_outputs_hiz = !serial_active &&
		serial_config_reg[`LDCFG_SP_HIZ_BIT]; // RULE8
	// Ring indicate survives low power
	assign serial_ring_irq = serial_active && serial_ring_irq_enable &&
		serial_ring_indicate_input; // RULE5
	// Power mode does not gate register access
	assign serial_regs_accessible = serial_active; // RULE6

	// -----------------------------------------------------------------
	// Wake control unit registers
	// -----------------------------------------------------------------
	// Activate register, bit 0 only
	ldcfg_mask_reg #(
		.RESET_VALUE(`LDCFG_RST_WAKE_ACTIVATE), // RULE9
		.WRITE_MASK(`LDCFG_ACTIVATE_WRITE_MASK)
	) i_wake_activate (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.write_strobe(wr_wake_activate),
		.write_data(wbyte),
		.value(wake_activate_reg)
	);

	// Base address high byte, every bit writable
	ldcfg_mask_reg #(
		.RESET_VALUE(`LDCFG_RST_WAKE_BASE), // RULE11
		.WRITE_MASK(`LDCFG_FULL_WRITE_MASK) // RULE14
	) i_wake_base_high (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.write_strobe(wr_wake_base_high),
		.write_data(wbyte),
		.value(wake_base_high_reg)
	);

	// Base address low byte, aligned on 32 bytes
	ldcfg_mask_reg #(
		.RESET_VALUE(`LDCFG_RST_WAKE_BASE), // RULE11
		.WRITE_MASK(`LDCFG_BASE_LOW_WRITE_MASK) // RULE11
	) i_wake_base_low (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.write_strobe(wr_wake_base_low),
		.write_data(wbyte),
		.value(wake_base_low_reg)
	);

	// Interrupt number, every bit writable
	ldcfg_mask_reg #(
		.RESET_VALUE(`LDCFG_RST_WAKE_IRQ_NUMBER),
		.WRITE_MASK(`LDCFG_FULL_WRITE_MASK) // RULE14
	) i_wake_irq_number (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.write_strobe(wr_wake_irq_number),
		.write_data(wbyte),
		.value(wake_irq_number_reg)
	);

	// Interrupt type, only bit 1 writable
	ldcfg_mask_reg #(
		.RESET_VALUE(`LDCFG_RST_WAKE_IRQ_TYPE), // RULE12
		.WRITE_MASK(`LDCFG_IRQ_TYPE_WRITE_MASK) // RULE12
	) i_wake_irq_type (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.write_strobe(wr_wake_irq_type),
		.write_data(wbyte),
		.value(wake_irq_type_reg)
	);

	// Wake unit outputs; detection never depends on activation
	assign wake_runtime_access_en = wake_activate_reg[0]; // RULE9
	assign wake_detect_enable = 1'b1; // RULE10
	assign wake_base_high = wake_base_high_reg;
	assign wake_base_low = wake_base_low_reg;
	assign wake_irq_number = wake_irq_number_reg;
	assign wake_irq_type = wake_irq_type_reg;

	// -----------------------------------------------------------------
	// Read path
	// -----------------------------------------------------------------
	// Read mux; unmapped indices read zero
	always_comb begin
		read_next = 8'h00;
		unique case (avs_address)
			`LDCFG_IDX_SERIAL_CONFIG: begin
				read_next = serial_config_reg;
				read_next[`LDCFG_SP_BUSY_BIT] = serial_busy; // RULE3
			end
			`LDCFG_IDX_SERIAL_ACTIVATE: read_next = serial_activate_reg;
			`LDCFG_IDX_WAKE_ACTIVATE: read_next = wake_activate_reg;
			`LDCFG_IDX_WAKE_BASE_HIGH: read_next = wake_base_high_reg;
			`LDCFG_IDX_WAKE_BASE_LOW: read_next = wake_base_low_reg;
			`LDCFG_IDX_WAKE_IRQ_NUMBER: read_next = wake_irq_number_reg;
			`LDCFG_IDX_WAKE_IRQ_TYPE: read_next = wake_irq_type_reg;
			`LDCFG_IDX_WAKE_DMA_A: read_next = `LDCFG_VAL_NO_DMA; // RULE13
			`LDCFG_IDX_WAKE_DMA_B: read_next = `LDCFG_VAL_NO_DMA; // RULE13
			default: read_next = 8'h00;
		endcase
	end

	// Read data captured when the request is first seen
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			readdata_reg <= 32'h0000_0000;
		end else if (clk_en && state_reg == LDCFG_IDLE && avs_read) begin
			readdata_reg <= {24'h00_0000, read_next};
		end
	end

	assign avs_readdata = readdata_reg;
endmodule // ldcfg_regs

// -----------------------------------------------------------------
// Register cell
// -----------------------------------------------------------------
// One byte of configuration state with a per-bit write mask
// Bits outside the mask never leave their reset value, which keeps
// read-only and reserved bits fixed whatever software writes
module ldcfg_mask_reg #(
	parameter logic [7:0] RESET_VALUE = 8'h00,
	parameter logic [7:0] WRITE_MASK = 8'hff
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic write_strobe,
	input wire logic [7:0] write_data,
	output logic [7:0] value
);
	// Masked update; the strobe already carries the clock enable
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			value <= RESET_VALUE;
		end else if (write_strobe) begin
			value <= (value & ~WRITE_MASK) | (write_data & WRITE_MASK);
		end
	end
endmodule // ldcfg_mask_reg

`default_nettype wire

// *** rtl/ldcfg_defines.svh ***
// Register offsets, field positions and reset values of the config bank
`ifndef LDCFG_DEFINES_SVH
`define LDCFG_DEFINES_SVH

// Indices of the configuration registers, byte address is index times four
`define LDCFG_IDX_WAKE_ACTIVATE 8'h30
`define LDCFG_IDX_WAKE_BASE_HIGH 8'h60
`define LDCFG_IDX_WAKE_BASE_LOW 8'h61
`define LDCFG_IDX_WAKE_IRQ_NUMBER 8'h70
`define LDCFG_IDX_WAKE_IRQ_TYPE 8'h71
`define LDCFG_IDX_WAKE_DMA_A 8'h74
`define LDCFG_IDX_WAKE_DMA_B 8'h75
`define LDCFG_IDX_SERIAL_CONFIG 8'hf0
// Activate register of the serial port, bit 0 switches it on
`define LDCFG_IDX_SERIAL_ACTIVATE 8'h31

// Reset values
`define LDCFG_RST_WAKE_ACTIVATE 8'h00
`define LDCFG_RST_WAKE_BASE 8'h00
`define LDCFG_RST_WAKE_IRQ_NUMBER 8'h00
`define LDCFG_RST_WAKE_IRQ_TYPE 8'h03
`define LDCFG_VAL_NO_DMA 8'h04
`define LDCFG_RST_SERIAL_CONFIG 8'h02
`define LDCFG_RST_SERIAL_ACTIVATE 8'h00

// Field positions of the serial port configuration register
`define LDCFG_SP_BANK_EN_BIT 7
`define LDCFG_SP_BUSY_BIT 2
`define LDCFG_SP_POWER_BIT 1
`define LDCFG_SP_HIZ_BIT 0
// Writable bits of mixed registers
`define LDCFG_SP_WRITE_MASK 8'h83
`define LDCFG_BASE_LOW_WRITE_MASK 8'he0
`define LDCFG_IRQ_TYPE_WRITE_MASK 8'h02
`define LDCFG_ACTIVATE_WRITE_MASK 8'h01
`define LDCFG_FULL_WRITE_MASK 8'hff

`endif

// *** rtl/ldcfg_pkg.sv ***
// Types shared by the configuration register bank
package ldcfg_pkg;
	typedef logic [7:0] ldcfg_byte_t;
	typedef enum logic [1:0] {
		LDCFG_IDLE = 2'b01,
		LDCFG_DONE = 2'b10
	} ldcfg_state_t;
endpackage

// *** testbench/ldcfg_regs_chk.sv ***
// Assertion checker for the config register bank
`timescale 1ns/1ps
`default_nettype none
`include "ldcfg_defines.svh"
module ldcfg_regs_chk
	import ldcfg_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic avs_waitrequest,
	input wire logic serial_ring_indicate_input,
	input wire logic serial_ring_irq_enable,
	input wire logic serial_ext_bank_req,
	input wire logic serial_ext_bank_grant,
	input wire logic serial_active,
	input wire logic serial_clk_enable,
	input wire logic serial_outputs_inactive,
	input wire logic serial_outputs_hiz,
	input wire logic serial_ring_irq,
	input wire logic wake_runtime_access_en,
	input wire logic wake_detect_enable,
	input wire ldcfg_byte_t wake_base_high,
	input wire ldcfg_byte_t wake_base_low,
	input wire ldcfg_byte_t wake_irq_type
);
	// ----
	// Properties on the system clock
	// ----
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
		&& clk_en |=> !avs_waitrequest) else $error("bus answer late");
	chk_base_write: assert property (avs_write && !avs_waitrequest &&
		avs_address == `LDCFG_IDX_WAKE_BASE_HIGH |=>
		{24'h000000, wake_base_high} == ($past(avs_writedata) & 32'h000000ff))
		else $error("base high write lost");
	chk_act_write: assert property (avs_write && !avs_waitrequest &&
		avs_address == `LDCFG_IDX_WAKE_ACTIVATE |=>
		{31'h0, wake_runtime_access_en} == ($past(avs_writedata) & 32'h1))
		else $error("activate write lost");
	chk_clk_gate: assert property (serial_outputs_inactive == !serial_clk_enable)
		else $error("outputs not inactive");
	chk_clk_active: assert property (serial_clk_enable |-> serial_active)
		else $error("clock on while inactive");
	chk_hiz_idle: assert property (serial_outputs_hiz |-> !serial_active)
		else $error("pins floated while active");
	chk_ring_irq: assert property (serial_ring_irq == (serial_active &&
		serial_ring_irq_enable && serial_ring_indicate_input))
		else $error("ring interrupt wrong");
	chk_grant_req: assert property (serial_ext_bank_grant |-> serial_ext_bank_req)
		else $error("bank grant without request");
	chk_detect_on: assert property (wake_detect_enable)
		else $error("wake detection off");
	chk_base_align: assert property (wake_base_low[4:0] == 5'h00)
		else $error("base low not aligned");
	chk_type_ro: assert property ((wake_irq_type & 8'hfd) == 8'h01)
		else $error("irq type read-only bits changed");
	cover property (serial_outputs_hiz);
	cover property (serial_ring_irq);
	cover property (serial_ext_bank_grant);
endmodule // ldcfg_regs_chk
bind ldcfg_regs ldcfg_regs_chk i_chk (.clk_sys, .rstn, .clk_en, .avs_address,
	.avs_read, .avs_write, .avs_writedata, .avs_waitrequest,
	.serial_ring_indicate_input, .serial_ring_irq_enable, .serial_ext_bank_req,
	.serial_ext_bank_grant, .serial_active, .serial_clk_enable,
	.serial_outputs_inactive, .serial_outputs_hiz, .serial_ring_irq,
	.wake_runtime_access_en, .wake_detect_enable, .wake_base_high,
	.wake_base_low, .wake_irq_type);
`default_nettype wire

// *** testbench/ldcfg_regs_bench.sv ***
// Self-checking bench for the config register bank
`timescale 1ns/1ps
`default_nettype none
module ldcfg_regs_bench;
	import ldcfg_pkg::*;
	typedef struct packed {logic [7:0] a, rst, w, e;} ldcfg_row_t;
	ldcfg_row_t rows[10] = '{32'h30000101, 32'h6000a5a5, 32'h6100ffe0,
		32'h70005a5a, 32'h71030001, 32'h7404ff04, 32'h75040004,
		32'hf002ff83, 32'h31000101, 32'h4000ff00};
	logic clk_sys, rstn, clk_en, avs_read, avs_write, avs_waitrequest;
	logic [7:0] avs_address, q;
	logic [31:0] avs_writedata, avs_readdata;
	logic serial_busy, serial_ring_indicate_input, serial_ring_irq_enable;
	logic serial_ext_bank_req, serial_ext_bank_grant, serial_active;
	logic serial_clk_enable, serial_outputs_inactive, serial_outputs_hiz;
	logic serial_ring_irq, serial_regs_accessible, wake_runtime_access_en;
	logic wake_detect_enable;
	ldcfg_byte_t wake_base_high, wake_base_low, wake_irq_number, wake_irq_type;
	int n_fail = 0;
	int checks_done = 0;
	int cycles = 0;
	ldcfg_regs i_dut (.clk_sys, .rstn, .clk_en, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
		.serial_busy, .serial_ring_indicate_input, .serial_ring_irq_enable,
		.serial_ext_bank_req, .serial_ext_bank_grant, .serial_active,
		.serial_clk_enable, .serial_outputs_inactive, .serial_outputs_hiz,
		.serial_ring_irq, .serial_regs_accessible, .wake_runtime_access_en,
		.wake_detect_enable, .wake_base_high, .wake_base_low,
		.wake_irq_number, .wake_irq_type);
	// ----
	// Bus, compare and verdict tasks
	// ----
	task automatic xfer(input logic wr, input logic [7:0] a, d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_read <= !wr;
		avs_write <= wr;
		avs_writedata <= {24'h000000, d};
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		#1; // Let the answer edge land before looking
	endtask
	task automatic chk(input logic [31:0] seen, exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results;
		if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// Cut a hang short
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_fail++;
			results();
		end
	end
	// ----
	// Main sequence
	// ----
	initial begin
		{rstn, avs_read, avs_write, serial_busy, serial_ext_bank_req} = 5'h00;
		{serial_ring_indicate_input, serial_ring_irq_enable} = 2'h0;
		clk_en = 1'b1;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
		foreach (rows[i]) begin
			xfer(1'b0, rows[i].a, 8'h00);
			chk(q, rows[i].rst, "reset value");
		end
		foreach (rows[i]) begin
			xfer(1'b1, rows[i].a, rows[i].w);
			xfer(1'b0, rows[i].a, 8'h00);
			chk(q, rows[i].e, "readback");
		end
		chk({wake_runtime_access_en, wake_base_high}, 9'h1a5, "wake");
		chk({wake_base_low, wake_irq_number, wake_irq_type}, 24'he05a01, "irq");
		@(posedge clk_sys) {serial_busy, serial_ext_bank_req} <= 2'h3;
		xfer(1'b0, 8'hf0, 8'h00);
		chk(q, 8'h87, "busy");
		chk({serial_ext_bank_grant, serial_clk_enable}, 2'h3, "grant");
		xfer(1'b1, 8'hf0, 8'h00);
		@(posedge clk_sys) {serial_ring_indicate_input, serial_ring_irq_enable} <= 2'h3;
		xfer(1'b0, 8'hf0, 8'h00);
		chk(q, 8'h04, "low power read");
		chk(serial_ext_bank_grant, 1'h0, "grant off");
		chk({serial_clk_enable, serial_outputs_inactive}, 2'h1, "clk off");
		chk(serial_ring_irq, 1'h1, "ring irq");
		chk(serial_regs_accessible, 1'h1, "access low power");
		chk(avs_readdata[31:8], 24'h0, "upper read bits");
		xfer(1'b1, 8'hf0, 8'h01);
		xfer(1'b1, 8'h31, 8'h00);
		chk(serial_outputs_hiz, 1'h1, "hiz");
		chk(serial_regs_accessible, 1'h0, "access inactive");
		xfer(1'b1, 8'h30, 8'h00);
		xfer(1'b0, 8'h60, 8'h00);
		chk(q, 8'ha5, "kept");
		chk({wake_runtime_access_en, wake_detect_enable}, 2'h1, "wake off");
		@(posedge clk_sys) rstn <= 1'b0;
		@(posedge clk_sys) rstn <= 1'b1;
		xfer(1'b0, 8'hf0, 8'h00);
		chk(q, 8'h06, "second reset");
		// Clock enable low freezes a pending write
		@(posedge clk_sys) clk_en <= 1'b0;
		avs_address <= 8'h60;
		avs_writedata <= 32'h0000_003c;
		avs_write <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk({avs_waitrequest, wake_base_high}, 9'h100, "frozen");
		clk_en <= 1'b1;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		#1;
		chk(wake_base_high, 8'h3c, "thawed write");
		results();
	end
endmodule // ldcfg_regs_bench
`default_nettype wire
